// ==== hw/bidir_fifo_mailbox_parity.sv ====
// flag, mailbox and parity logic of a two-port bidirectional queue device
// assumes both port buses are resolved outside from the output enables
// and that every port control input is synchronous to mclk
//
// Behaviour
// - B-to-A queue flags follow fill level table
// - almost-full rises on second edge after read
// - late read edge pushes the update one cycle
// - one 36-bit mail register per direction
// - port A mail write loads A-to-B register
// - port B mail write loads B-to-A register
// - mail write lowers flag; writes ignored while low
// - outputs from queue or mail by mailbox select
// - port B mail read raises A-to-B flag
// - port A mail read raises B-to-A flag
// - mail read leaves stored word unchanged
// - four 9-bit bytes, top bit is parity
// - parity error low when any byte fails
// - port A mail read with generation forces no-error
// - port B mail read with generation forces no-error
// - generation replaces top bit from low eight
// - writes store all 36 levels unchanged
// - queue parity sampled on output-register load edge
// - mail parity generation never alters stored word
// - reads ignored while empty flag low
// - writes ignored while full flag low
// - flags pass two register stages when released
// - offset loaded from four presets once after reset release
`timescale 1ns/1ps

// ****************************************
// one direction of storage with its flags
// ****************************************
module bidir_queue
	import bidir_fifo_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic                      clkEn,
	input  wire logic [$clog2(DEPTH):0]    offset,
	input  wire logic                      oddSel,
	input  wire logic                      wrReq,
	input  wire logic [DATA_W-1:0]         wrData,
	input  wire logic                      rdReq,
	input  wire logic                      parityGenerate,
	output logic [DATA_W-1:0]              outWord,
	output logic                           emptyN,
	output logic                           almostEmptyN,
	output logic                           almostFullN,
	output logic                           fullN
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [DATA_W-1:0] mem [0:DEPTH-1];
	logic [AW:0]       wrPtr_reg;
	logic [AW:0]       rdPtr_reg;
	logic [AW:0]       wrPtr_next;
	logic [AW:0]       rdPtr_next;
	logic [AW:0]       fill_next;
	logic [AW:0]       fillNow;
	logic              wrTake;
	logic              rdTake;
	logic              emptyRaw;
	logic              almostEmptyRaw;
	logic              almostFullRaw;
	logic              fullRaw;
	logic [3:0]        stage_reg;

	assign wrTake = wrReq & fullN;
	assign rdTake = rdReq & emptyN;
	assign wrPtr_next = wrPtr_reg + {{AW{1'b0}}, wrTake};
	assign rdPtr_next = rdPtr_reg + {{AW{1'b0}}, rdTake};
	assign fill_next = wrPtr_next - rdPtr_next;
	assign fillNow = wrPtr_reg - rdPtr_reg;
	assign emptyRaw = (fill_next == '0);
	assign almostEmptyRaw = (fill_next <= offset);
	assign almostFullRaw = (fill_next >= DEPTH_C - offset);
	assign fullRaw = (fill_next == DEPTH_C);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end else if (clkEn) begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
		end
	end

	// storage has no reset: only words already written are ever read
	always_ff @(posedge mclk) begin
		if (clkEn && wrTake) begin
			mem[wrPtr_reg[AW-1:0]] <= wrData;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			outWord <= MAIL_RESET;
		end else if (clkEn && rdTake) begin
			outWord <= parityGenerate ? parity_fill(mem[rdPtr_reg[AW-1:0]], oddSel)
			                          : mem[rdPtr_reg[AW-1:0]];
		end
	end

	// a flag drops on the edge of the op that causes it; the release path samples
	// the settled pointers, so a release lands on the second edge after the op
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage_reg    <= 4'h3;
			emptyN       <= 1'b0;
			almostEmptyN <= 1'b0;
			almostFullN  <= 1'b1;
			fullN        <= 1'b1;
		end else if (clkEn) begin
			stage_reg    <= {(fillNow != '0), (fillNow > offset),
			                 (fillNow < DEPTH_C - offset), (fillNow != DEPTH_C)};
			emptyN       <= stage_reg[3] & ~emptyRaw;
			almostEmptyN <= stage_reg[2] & ~almostEmptyRaw;
			almostFullN  <= stage_reg[1] & ~almostFullRaw;
			fullN        <= stage_reg[0] & ~fullRaw;
		end
	end
endmodule

// ****************************************
// top: two ports, two queues, two mail registers
// ****************************************
module bidir_fifo_mailbox_parity
	import bidir_fifo_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                clkEn,
	input  wire logic [1:0]          offsetSelect,
	input  wire logic                oddSel,
	input  port_ctrl_t               portACtrl,
	input  wire logic [DATA_W-1:0]   portABusIn,
	output logic [DATA_W-1:0]        portABusOut,
	output logic                     portABusOe,
	input  port_ctrl_t               portBCtrl,
	input  wire logic [DATA_W-1:0]   portBBusIn,
	output logic [DATA_W-1:0]        portBBusOut,
	output logic                     portBBusOe,
	output logic                     portAEmptyN,
	output logic                     portAAlmostEmptyN,
	output logic                     portAAlmostFullN,
	output logic                     portAFullN,
	output logic                     portBEmptyN,
	output logic                     portBAlmostEmptyN,
	output logic                     portBAlmostFullN,
	output logic                     portBFullN,
	output logic                     aToBMailFlagN,
	output logic                     bToAMailFlagN,
	output logic                     portAParityErrorN,
	output logic                     portBParityErrorN
);
	localparam int AW = $clog2(DEPTH);

	logic [CNT_W-1:0]  offset_reg;
	logic              offsetLoaded_reg;
	logic [DATA_W-1:0] aToBMailRegister_reg;
	logic [DATA_W-1:0] bToAMailRegister_reg;
	logic [DATA_W-1:0] aToBQueueOut;
	logic [DATA_W-1:0] bToAQueueOut;
	logic              aWrite;
	logic              aRead;
	logic              bWrite;
	logic              bRead;
	logic              aMailWrite;
	logic              bMailWrite;
	logic              aMailRead;
	logic              bMailRead;

	// ****************************************
	// port decode
	// ****************************************
	assign aWrite = ~portACtrl.csN & portACtrl.enable & portACtrl.writeNotRead;
	assign aRead  = ~portACtrl.csN & portACtrl.enable & ~portACtrl.writeNotRead;
	assign bWrite = ~portBCtrl.csN & portBCtrl.enable & portBCtrl.writeNotRead;
	assign bRead  = ~portBCtrl.csN & portBCtrl.enable & ~portBCtrl.writeNotRead;
	assign aMailWrite = aWrite & portACtrl.mailboxSelect & aToBMailFlagN;
	assign bMailWrite = bWrite & portBCtrl.mailboxSelect & bToAMailFlagN;
	assign aMailRead  = aRead & portACtrl.mailboxSelect;
	assign bMailRead  = bRead & portBCtrl.mailboxSelect;

	// ****************************************
	// offset preset, taken once after reset release
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			offset_reg       <= OFFSET_RESET;
			offsetLoaded_reg <= 1'b0;
		end else if (clkEn && !offsetLoaded_reg) begin
			offsetLoaded_reg <= 1'b1;
			case (offsetSelect)
				2'h0:    offset_reg <= OFFSET_PRESET0;
				2'h1:    offset_reg <= OFFSET_PRESET1;
				2'h2:    offset_reg <= OFFSET_PRESET2;
				default: offset_reg <= OFFSET_PRESET3;
			endcase
		end
	end

	// ****************************************
	// the two queues
	// ****************************************
	bidir_queue #(.DEPTH(DEPTH)) aToBQueue (
		.mclk           (mclk),
		.rst_n          (rst_n),
		.clkEn          (clkEn),
		.offset         (offset_reg[AW:0]),
		.oddSel         (oddSel),
		.wrReq          (aWrite & ~portACtrl.mailboxSelect),
		.wrData         (portABusIn),
		.rdReq          (bRead & ~portBCtrl.mailboxSelect),
		.parityGenerate (portBCtrl.parityGenerate),
		.outWord        (aToBQueueOut),
		.emptyN         (portBEmptyN),
		.almostEmptyN   (portBAlmostEmptyN),
		.almostFullN    (portAAlmostFullN),
		.fullN          (portAFullN)
	);

	bidir_queue #(.DEPTH(DEPTH)) bToAQueue (
		.mclk           (mclk),
		.rst_n          (rst_n),
		.clkEn          (clkEn),
		.offset         (offset_reg[AW:0]),
		.oddSel         (oddSel),
		.wrReq          (bWrite & ~portBCtrl.mailboxSelect),
		.wrData         (portBBusIn),
		.rdReq          (aRead & ~portACtrl.mailboxSelect),
		.parityGenerate (portACtrl.parityGenerate),
		.outWord        (bToAQueueOut),
		.emptyN         (portAEmptyN),
		.almostEmptyN   (portAAlmostEmptyN),
		.almostFullN    (portBAlmostFullN),
		.fullN          (portBFullN)
	);

	// ****************************************
	// mail registers and their flags
	// ****************************************
	// only an accepted write changes the word; reads never touch it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aToBMailRegister_reg <= MAIL_RESET;
			bToAMailRegister_reg <= MAIL_RESET;
		end else if (clkEn) begin
			if (aMailWrite) begin
				aToBMailRegister_reg <= portABusIn;
			end
			if (bMailWrite) begin
				bToAMailRegister_reg <= portBBusIn;
			end
		end
	end

	// an accepted write in the same cycle as the far-side read wins and lowers the flag
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aToBMailFlagN <= 1'b1;
			bToAMailFlagN <= 1'b1;
		end else if (clkEn) begin
			if (aMailWrite) begin
				aToBMailFlagN <= 1'b0;
			end else if (bMailRead) begin
				aToBMailFlagN <= 1'b1;
			end
			if (bMailWrite) begin
				bToAMailFlagN <= 1'b0;
			end else if (aMailRead) begin
				bToAMailFlagN <= 1'b1;
			end
		end
	end

	// ****************************************
	// data outputs
	// ****************************************
	// registered mux costs one cycle of latency but keeps the pins glitch free
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			portABusOut <= MAIL_RESET;
			portBBusOut <= MAIL_RESET;
			portABusOe  <= 1'b0;
			portBBusOe  <= 1'b0;
		end else if (clkEn) begin
			portABusOe <= ~portACtrl.csN & ~portACtrl.writeNotRead;
			portBBusOe <= ~portBCtrl.csN & ~portBCtrl.writeNotRead;
			if (portACtrl.mailboxSelect) begin
				portABusOut <= portACtrl.parityGenerate
				               ? parity_fill(bToAMailRegister_reg, oddSel)
				               : bToAMailRegister_reg;
			end else begin
				portABusOut <= bToAQueueOut;
			end
			if (portBCtrl.mailboxSelect) begin
				portBBusOut <= portBCtrl.parityGenerate
				               ? parity_fill(aToBMailRegister_reg, oddSel)
				               : aToBMailRegister_reg;
			end else begin
				portBBusOut <= aToBQueueOut;
			end
		end
	end

	// ****************************************
	// parity checking
	// ****************************************
	// the trees are busy generating during a mail read with parityGenerate high, so the check is blanked
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			portAParityErrorN <= 1'b1;
			portBParityErrorN <= 1'b1;
		end else if (clkEn) begin
			if (aMailRead && portACtrl.parityGenerate) begin
				portAParityErrorN <= 1'b1;
			end else begin
				portAParityErrorN <= ~word_error(portABusIn, oddSel);
			end
			if (bMailRead && portBCtrl.parityGenerate) begin
				portBParityErrorN <= 1'b1;
			end else begin
				portBParityErrorN <= ~word_error(portBBusIn, oddSel);
			end
		end
	end
endmodule

// ==== common/bidir_fifo_pkg.sv ====
// constants, carrier types and parity helpers for the bidirectional queue block
// assumes both ports are sampled on one common clock
package bidir_fifo_pkg;

	// ****************************************
	// geometry and reset values
	// ****************************************
	localparam int             DATA_W      = 36;
	localparam int             BYTE_W      = 9;
	localparam int             BYTE_COUNT  = 4;
	localparam int             QUEUE_DEPTH = 64;
	localparam int             CNT_W       = 7;
	localparam logic [CNT_W-1:0] OFFSET_PRESET0 = 7'h04;
	localparam logic [CNT_W-1:0] OFFSET_PRESET1 = 7'h08;
	localparam logic [CNT_W-1:0] OFFSET_PRESET2 = 7'h10;
	localparam logic [CNT_W-1:0] OFFSET_PRESET3 = 7'h20;
	localparam logic [CNT_W-1:0] OFFSET_RESET   = 7'h08;
	localparam logic [DATA_W-1:0] MAIL_RESET    = 36'h000000000;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic csN;
		logic writeNotRead;
		logic enable;
		logic mailboxSelect;
		logic parityGenerate;
	} port_ctrl_t;

	// ****************************************
	// parity helpers
	// ****************************************
	// oddSel high: each byte must carry an even count of low bits
	function automatic logic byte_error(input logic [BYTE_W-1:0] b, input logic oddSel);
		logic lowsOdd;
		lowsOdd = ^(~b);
		return oddSel ? lowsOdd : ~lowsOdd;
	endfunction

	function automatic logic word_error(input logic [DATA_W-1:0] w, input logic oddSel);
		logic err;
		err = 1'b0;
		for (int i = 0; i < BYTE_COUNT; i++) begin
			err = err | byte_error(w[i*BYTE_W +: BYTE_W], oddSel);
		end
		return err;
	endfunction

	function automatic logic [DATA_W-1:0] parity_fill(input logic [DATA_W-1:0] w,
			input logic oddSel);
		logic [DATA_W-1:0] r;
		r = w;
		for (int i = 0; i < BYTE_COUNT; i++) begin
			r[i*BYTE_W + BYTE_W - 1] = oddSel ^ (^(~w[i*BYTE_W +: BYTE_W-1]));
		end
		return r;
	endfunction

endpackage

// ==== verif/port_host_model.sv ====
// host on one port of the queue device: drives control and write data
// assumes the bench calls op once per cycle; the device bus is resolved here
`timescale 1ns/1ps

// ****************************************
// port host
// ****************************************
module port_host_model
	import bidir_fifo_pkg::*;
(
	input	wire logic [DATA_W-1:0]	busOut,
	input	wire logic	busOe,
	input	wire logic	mclk,
	output	port_ctrl_t	ctrl,
	output	logic [DATA_W-1:0]	busIn
);
	logic [DATA_W-1:0]	drv;
	logic	hostOe;

	initial begin
		ctrl = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
		drv = 36'h000000000;
		hostOe = 1'h0;
	end

	// host drive wins: the device output enable lags a read-to-write turn by a cycle
	// a released bus shows the inverse of the last drive, never a held value
	assign busIn = hostOe ? drv : (busOe ? busOut : ~drv);

	// c = {enable, writeNotRead, mailboxSelect, parityGenerate}
	task automatic op(input logic [3:0] c, input logic [DATA_W-1:0] d);
		@(negedge mclk);
		ctrl = '{1'h0, c[2], c[3], c[1], c[0]};
		drv = d;
		hostOe = c[2];
	endtask
endmodule

// ==== verif/bidir_fifo_mailbox_parity_chk.sv ====
// timing checks on the ports of the queue device
// assumes one clock domain and clkEn held high while ops run
`timescale 1ns/1ps

// ****************************************
// checker
// ****************************************
module bidir_fifo_mailbox_parity_chk
	import bidir_fifo_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	input	wire logic	mclk,
	input	wire logic	rst_n,
	input	wire logic	clkEn,
	input	port_ctrl_t	portACtrl,
	input	port_ctrl_t	portBCtrl,
	input	wire logic	portABusOe,
	input	wire logic	portBBusOe,
	input	wire logic	portAEmptyN,
	input	wire logic	portAAlmostEmptyN,
	input	wire logic	portBAlmostFullN,
	input	wire logic	portBFullN,
	input	wire logic	aToBMailFlagN,
	input	wire logic	bToAMailFlagN,
	input	wire logic	portAParityErrorN,
	input	wire logic	portBParityErrorN
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic	aGo, bGo, aMw, bMw, aMr, bMr;
	assign aGo = clkEn && !portACtrl.csN && portACtrl.enable;
	assign bGo = clkEn && !portBCtrl.csN && portBCtrl.enable;
	assign aMw = aGo && portACtrl.writeNotRead && portACtrl.mailboxSelect;
	assign bMw = bGo && portBCtrl.writeNotRead && portBCtrl.mailboxSelect;
	assign aMr = aGo && !portACtrl.writeNotRead && portACtrl.mailboxSelect;
	assign bMr = bGo && !portBCtrl.writeNotRead && portBCtrl.mailboxSelect;

	a_mail_a_load: assert property (aMw && aToBMailFlagN |=> !aToBMailFlagN)
		else $error("a-to-b mail flag not lowered by write");
	a_mail_b_load: assert property (bMw && bToAMailFlagN |=> !bToAMailFlagN)
		else $error("b-to-a mail flag not lowered by write");
	a_mail_flag_hold: assert property (!aToBMailFlagN && !bMr |=> !aToBMailFlagN)
		else $error("a-to-b mail flag rose without a read");
	a_mail_b_take: assert property (bMr && !aMw |=> aToBMailFlagN)
		else $error("port b mail read left flag low");
	a_mail_a_take: assert property (aMr && !bMw |=> bToAMailFlagN)
		else $error("port a mail read left flag low");
	a_pef_a_forced: assert property (aMr && portACtrl.parityGenerate |=> portAParityErrorN)
		else $error("port a parity error during generated mail read");
	a_pef_b_forced: assert property (bMr && portBCtrl.parityGenerate |=> portBParityErrorN)
		else $error("port b parity error during generated mail read");
	a_full_has_af: assert property (!portBFullN |-> !portBAlmostFullN)
		else $error("full without almost-full");
	a_empty_has_ae: assert property (!portAEmptyN |-> !portAAlmostEmptyN)
		else $error("empty without almost-empty");
	a_af_two_edges: assert property ($rose(portBAlmostFullN) |->
		$past(aGo && !portACtrl.writeNotRead && !portACtrl.mailboxSelect && portAEmptyN, 3))
		else $error("almost-full rose not two edges after a read");
	a_read_drives: assert property (clkEn && !portACtrl.csN && !portACtrl.writeNotRead
		|=> portABusOe)
		else $error("port a bus not driven on read");
	a_read_drives_b: assert property (clkEn && !portBCtrl.csN && !portBCtrl.writeNotRead
		|=> portBBusOe)
		else $error("port b bus not driven on read");

	cover property ($fell(aToBMailFlagN) ##[1:20] aToBMailFlagN);
	cover property ($rose(portBAlmostFullN));
	cover property ($fell(portAParityErrorN));
endmodule

bind bidir_fifo_mailbox_parity bidir_fifo_mailbox_parity_chk #(.DEPTH(DEPTH))
	i_bidir_fifo_mailbox_parity_chk (.mclk, .rst_n, .clkEn, .portACtrl, .portBCtrl,
	.portABusOe, .portBBusOe, .portAEmptyN, .portAAlmostEmptyN, .portBAlmostFullN,
	.portBFullN, .aToBMailFlagN, .bToAMailFlagN, .portAParityErrorN, .portBParityErrorN);

// ==== verif/bidir_fifo_mailbox_parity_tb_top.sv ====
// self-checking bench for the queue device: queue flags, mail, parity
// assumes one host model per port and clkEn, offsetSelect tied (offset 4)
`timescale 1ns/1ps

module bidir_fifo_mailbox_parity_tb_top
	import bidir_fifo_pkg::*;
;
	// op codes {enable, writeNotRead, mailboxSelect, parityGenerate}
	localparam logic [3:0] MAIL_WR = 4'hE;
	localparam logic [3:0] MAIL_RD = 4'hA;
	localparam logic [3:0] Q_WR    = 4'hC;
	localparam logic [3:0] Q_RD    = 4'h8;

	logic	mclk, rst_n, oddSel, aOe, bOe;
	logic [DATA_W-1:0]	aIn, bIn, aOut, bOut;
	port_ctrl_t	aCtrl, bCtrl;
	logic [3:0]	a2bFlags;
	logic	portAEmptyN, portAAlmostEmptyN, portAAlmostFullN, portAFullN;
	logic	portBEmptyN, portBAlmostEmptyN, portBAlmostFullN, portBFullN;
	logic	aToBMailFlagN, bToAMailFlagN, portAParityErrorN, portBParityErrorN;
	int	nFail = 0;
	int	testsRun = 0;
	int	cyc = 0;

	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end

	bidir_fifo_mailbox_parity #(.DEPTH(64)) i_bidir_fifo_mailbox_parity (.mclk, .rst_n,
		.clkEn(1'h1), .offsetSelect(2'h0), .oddSel, .portACtrl(aCtrl), .portABusIn(aIn),
		.portABusOut(aOut), .portABusOe(aOe), .portBCtrl(bCtrl), .portBBusIn(bIn),
		.portBBusOut(bOut), .portBBusOe(bOe), .portAEmptyN, .portAAlmostEmptyN,
		.portAAlmostFullN, .portAFullN, .portBEmptyN, .portBAlmostEmptyN,
		.portBAlmostFullN, .portBFullN, .aToBMailFlagN, .bToAMailFlagN,
		.portAParityErrorN, .portBParityErrorN);
	assign a2bFlags = {portAFullN, portAAlmostFullN, portBEmptyN, portBAlmostEmptyN};
	port_host_model i_port_host_model_a (.mclk, .busOut(aOut), .busOe(aOe),
		.ctrl(aCtrl), .busIn(aIn));
	port_host_model i_port_host_model_b (.mclk, .busOut(bOut), .busOe(bOe),
		.ctrl(bCtrl), .busIn(bIn));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic opA(input logic [3:0] c, input logic [DATA_W-1:0] d);
		i_port_host_model_a.op(c, d);
	endtask
	task automatic opB(input logic [3:0] c, input logic [DATA_W-1:0] d);
		i_port_host_model_b.op(c, d);
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [DATA_W-1:0] w(input logic [3:0] f);
		return {32'h00000000, f};
	endfunction
	task automatic results();
		$display("checks=%0d mismatches=%0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_queue_flags();
		chk(w({portBFullN, portBAlmostFullN, portAEmptyN, portAAlmostEmptyN}), 36'h00000000C);
		// the 65th write meets a full queue and must vanish
		for (int i = 0; i < 65; i++) opB(Q_WR, DATA_W'(i));
		opB(4'h4, 36'h000000000);
		chk(w({portBFullN, portBAlmostFullN, portAEmptyN, portAAlmostEmptyN}), 36'h000000003);
		for (int i = 0; i < 5; i++) opA(Q_RD, 36'h000000000);
		opA(4'h0, 36'h000000000);
		chk(w({2'h0, portBFullN, portBAlmostFullN}), 36'h000000002);
		opA(4'h0, 36'h000000000);
		chk(w({2'h0, portBFullN, portBAlmostFullN}), 36'h000000002);
		opA(4'h0, 36'h000000000);
		chk(w({2'h0, portBFullN, portBAlmostFullN}), 36'h000000003);
		chk(aOut, 36'h000000004);
		$display("test_queue_flags done");
	endtask

	task automatic test_mail_a2b();
		opA(MAIL_WR, 36'h123456789);
		opA(4'h6, 36'h123456789);
		chk(w({3'h0, aToBMailFlagN}), 36'h000000000);
		opA(MAIL_WR, 36'hABCDEF012);
		opA(4'h6, 36'hABCDEF012);
		opB(MAIL_RD, 36'h000000000);
		opB(4'h2, 36'h000000000);
		chk(w({2'h0, aToBMailFlagN, bOe}), 36'h000000003);
		opB(MAIL_RD, 36'h000000000);
		opB(4'h2, 36'h000000000);
		chk(bOut, 36'h123456789);
		opB(4'h4, 36'h000000000);
		$display("test_mail_a2b done");
	endtask

	task automatic test_queue_a2b();
		// a read on the empty queue must not move its pointer
		opB(Q_RD, 36'h000000000);
		opB(4'h0, 36'h000000000);
		opA(Q_WR, 36'h155AA33CC);
		opA(4'h4, 36'h155AA33CC);
		chk(w(a2bFlags), 36'h00000000C);
		opB(4'h0, 36'h000000000);
		chk(w(a2bFlags), 36'h00000000C);
		opB(Q_RD, 36'h000000000);
		chk(w(a2bFlags), 36'h00000000E);
		opB(4'h0, 36'h000000000);
		opB(4'h0, 36'h000000000);
		chk(bOut, 36'h155AA33CC);
		chk(w(a2bFlags), 36'h00000000C);
		$display("test_queue_a2b done");
	endtask

	task automatic test_mail_b2a_gen();
		oddSel = 1'h1;
		opB(MAIL_WR, 36'h0000000FF);
		opB(4'h6, 36'h0000000FF);
		opA(MAIL_RD | 4'h1, 36'h000000000);
		opA(4'h3, 36'h000000000);
		opA(4'h3, 36'h000000000);
		chk(aOut, 36'h8040201FF);
		chk(w({2'h0, bToAMailFlagN, portAParityErrorN}), 36'h000000003);
		opA(4'h2, 36'h000000000);
		opA(4'h2, 36'h000000000);
		chk(aOut, 36'h0000000FF);
		$display("test_mail_b2a_gen done");
	endtask

	task automatic test_parity_check();
		// bus driven with no op; every byte of zeros holds nine low bits
		opA(4'h4, 36'h000000000);
		opA(4'h4, 36'h000000000);
		chk(w({3'h0, portAParityErrorN}), 36'h000000000);
		oddSel = 1'h0;
		opA(4'h4, 36'h000000000);
		chk(w({3'h0, portAParityErrorN}), 36'h000000001);
		opA(4'h4, 36'h000040000);
		opA(4'h4, 36'h000040000);
		chk(w({3'h0, portAParityErrorN}), 36'h000000000);
		$display("test_parity_check done");
	endtask

	// ****************************************
	// run control
	// ****************************************
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			nFail++;
			results();
		end
	end

	initial begin
		rst_n = 1'h0;
		oddSel = 1'h0;
		repeat (5) @(negedge mclk);
		rst_n = 1'h1;
		repeat (2) @(negedge mclk);
		test_queue_flags();
		test_mail_a2b();
		test_queue_a2b();
		test_mail_b2a_gen();
		test_parity_check();
		results();
	end
endmodule
